/* hdl/sysref_window_autocal.sv */
// reference-strobe window detector, capture select and automatic delay calibration
//
// Notes on behaviour
// - step control 0 gives coarse phase spacing, 1 gives fine spacing
// - lowest and highest capture flags always read as set
// - select value is the index of the chosen flag bit
// - 24 flags reported, select reaches only positions 0 to 15
// - flag one marks setup or hold risk, zero a valid position
// - flags valid only after three strobe rising edges
// - engine steps delay until clock falling edge meets strobe rise
// - search both polarities, keep the smallest aligning coarse delay
// - found delay readable in the calibration status field
// - calibrated delay stays applied while autocal stays enabled; disabling applies written values
// - software may disable autocal and write its own delay values
// - done flag rises at completion; software gates background calibration on it
// - captured strobe resets the local multiframe counter
// - device clock samples and clocks logic and serializers
// - up to 16 lanes at up to 12.8 Gbps each
`timescale 1ns/1ps
module sysref_window_autocal #(
    parameter int lmfc_period = 32
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic strobe_pin,
    input wire logic [23:0] phase_sample,
    input wire logic edge_early,
    output sysref_cal_pkg::delay_setting_t delay_applied,
    output sysref_cal_pkg::capture_ctrl_t capture_ctrl,
    output logic strobe_captured,
    output logic lmfc_reset,
    output logic [4:0] lmfc_count
);
    typedef enum {idle_st, settle_st, judge_st, done_st} cal_state_t;

    cal_state_t cal_reg;
    sysref_cal_pkg::delay_setting_t manual_reg;
    sysref_cal_pkg::delay_setting_t search_reg;
    sysref_cal_pkg::delay_setting_t result_reg;
    sysref_cal_pkg::delay_setting_t best_reg;
    sysref_cal_pkg::capture_ctrl_t ctrl_reg;
    logic enable_reg;
    logic done_reg;
    logic found_reg;
    logic [7:0] settle_cfg_reg;
    logic [7:0] settle_cnt_reg;
    logic [2:0] strobe_sync_reg;
    logic strobe_level_reg;
    logic [1:0] edge_cnt_reg;
    logic [23:0] flags_reg;
    logic [2:0] early_sync_reg;
    logic early_reg;
    logic ack_reg;
    logic [4:0] lmfc_reg;
    logic [4:0] scan_addr_reg;
    logic scan_bit;
    logic strobe_rise;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_next;

    function automatic logic hit(input logic [13:0] a, input logic [13:0] b);
        return a == b;
    endfunction

    // waitrequest high in the first cycle; writes land when it is low
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_hit = avs_write & ack_reg;
    assign rd_hit = avs_read & ~ack_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    // strobe pin synchroniser, change counted once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            strobe_sync_reg <= 3'h0;
            strobe_level_reg <= 1'b0;
            early_sync_reg <= 3'h0;
            early_reg <= 1'b0;
        end else begin
            strobe_sync_reg <= {strobe_sync_reg[1:0], strobe_pin};
            if (strobe_sync_reg[1] == strobe_sync_reg[2]) begin
                strobe_level_reg <= strobe_sync_reg[2];
            end
            early_sync_reg <= {early_sync_reg[1:0], edge_early};
            early_reg <= (early_sync_reg[1] == early_sync_reg[2]) ? early_sync_reg[2] : early_reg;
        end
    end
    assign strobe_rise = (strobe_sync_reg[1] == strobe_sync_reg[2]) & strobe_sync_reg[2]
        & ~strobe_level_reg;

    // capture flags: sample per strobe rise, valid after three rises
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            edge_cnt_reg <= 2'h0;
        end else if (strobe_rise && edge_cnt_reg != sysref_cal_pkg::valid_edge_count) begin
            edge_cnt_reg <= edge_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flags_reg <= '1;
        end else if (strobe_rise) begin
            // one marks a risky position, zero a valid one; ends pinned high
            flags_reg <= {1'b1, phase_sample[22:1], 1'b1};
        end
    end

    // per-position history kept in the store, scanned for the capture status
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scan_addr_reg <= 5'h00;
        end else if (scan_addr_reg == 5'(sysref_cal_pkg::flag_count - 1)) begin
            scan_addr_reg <= 5'h00;
        end else begin
            scan_addr_reg <= scan_addr_reg + 5'h01;
        end
    end

    phase_flag_store #(
        .depth(sysref_cal_pkg::flag_count)
    ) store_i (
        .ref_clk(ref_clk),
        .reset(reset),
        .wr_en(edge_cnt_reg == sysref_cal_pkg::valid_edge_count),
        .wr_addr(scan_addr_reg),
        .wr_data(flags_reg[scan_addr_reg]),
        .rd_addr({1'b0, ctrl_reg.select}),
        .rd_data(scan_bit)
    );

    // software control registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_reg <= '{select: sysref_cal_pkg::select_reset,
                step_fine: sysref_cal_pkg::step_fine_reset};
            settle_cfg_reg <= sysref_cal_pkg::settle_reset;
            enable_reg <= 1'b0;
            manual_reg <= '0;
        end else if (wr_hit && avs_byteenable[0]) begin
            if (hit(avs_address, sysref_cal_pkg::clock_ctrl_addr)) begin
                // select holds a flag index 0..15, step bit picks coarse or fine
                ctrl_reg.select <= avs_writedata[sysref_cal_pkg::select_lsb +: 4];
                ctrl_reg.step_fine <= avs_writedata[sysref_cal_pkg::step_fine_bit];
            end
            if (hit(avs_address, sysref_cal_pkg::autocal_enable_addr)) begin
                enable_reg <= avs_writedata[0];
            end
            if (hit(avs_address, sysref_cal_pkg::autocal_config_addr)) begin
                settle_cfg_reg <= avs_writedata[7:0];
            end
            if (hit(avs_address, sysref_cal_pkg::delay_ctrl_addr)) begin
                manual_reg.coarse <= avs_writedata[sysref_cal_pkg::coarse_lsb +: 8];
                manual_reg.fine <= avs_writedata[sysref_cal_pkg::fine_lsb +: 8];
                manual_reg.invert <= avs_writedata[sysref_cal_pkg::invert_bit];
            end
        end
    end
    assign capture_ctrl = ctrl_reg;

    // calibration engine: sweep coarse in both polarities, keep smallest aligning delay
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cal_reg <= idle_st;
            search_reg <= '0;
            best_reg <= '0;
            found_reg <= 1'b0;
            settle_cnt_reg <= 8'h00;
        end else if (!enable_reg) begin
            cal_reg <= idle_st;
        end else begin
            unique case (cal_reg)
                idle_st: begin
                    search_reg <= '0;
                    found_reg <= 1'b0;
                    settle_cnt_reg <= settle_cfg_reg;
                    cal_reg <= settle_st;
                end
                settle_st: begin
                    if (settle_cnt_reg == 8'h00) begin
                        cal_reg <= judge_st;
                    end else if (strobe_rise) begin
                        settle_cnt_reg <= settle_cnt_reg - 8'h01;
                    end
                end
                judge_st: begin
                    if (!early_reg && (!found_reg || search_reg.coarse < best_reg.coarse)) begin
                        best_reg <= search_reg;
                        found_reg <= 1'b1;
                    end
                    settle_cnt_reg <= settle_cfg_reg;
                    if (search_reg.coarse == 8'hFF) begin
                        if (search_reg.invert) begin
                            cal_reg <= done_st;
                        end else begin
                            search_reg <= '{invert: 1'b1, coarse: 8'h00, fine: 8'h00};
                            cal_reg <= settle_st;
                        end
                    end else if (!early_reg) begin
                        // first aligning coarse in this polarity is its smallest
                        search_reg.coarse <= 8'hFF;
                        cal_reg <= settle_st;
                    end else begin
                        search_reg.coarse <= search_reg.coarse + 8'h01;
                        cal_reg <= settle_st;
                    end
                end
                done_st: begin
                    cal_reg <= done_st;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_reg <= 1'b0;
            result_reg <= '0;
        end else if (cal_reg == judge_st && search_reg.coarse == 8'hFF && search_reg.invert) begin
            done_reg <= 1'b1;
            result_reg <= found_reg ? best_reg : search_reg;
        end else if (cal_reg == idle_st && enable_reg) begin
            done_reg <= 1'b0;
        end
    end

    // applied delay: search value while running, result after, written values otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            delay_applied <= '0;
        end else if (enable_reg && cal_reg != done_st) begin
            delay_applied <= search_reg;
        end else if (enable_reg) begin
            delay_applied <= result_reg;
        end else begin
            delay_applied <= manual_reg;
        end
    end

    // multiframe counter reset by the captured strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lmfc_reg <= 5'h00;
            strobe_captured <= 1'b0;
            lmfc_reset <= 1'b0;
        end else begin
            strobe_captured <= strobe_rise;
            lmfc_reset <= strobe_rise;
            if (strobe_rise || lmfc_reg == 5'(lmfc_period - 1)) begin
                lmfc_reg <= 5'h00;
            end else begin
                lmfc_reg <= lmfc_reg + 5'h01;
            end
        end
    end
    assign lmfc_count = lmfc_reg;

    // register read mux, unmapped reads as zero
    always_comb begin
        rd_next = sysref_cal_pkg::unmapped_read;
        if (hit(avs_address, sysref_cal_pkg::flags_low_addr)) begin
            rd_next = {24'h0, flags_reg[7:0]};
        end else if (hit(avs_address, sysref_cal_pkg::flags_mid_addr)) begin
            rd_next = {24'h0, flags_reg[15:8]};
        end else if (hit(avs_address, sysref_cal_pkg::flags_high_addr)) begin
            rd_next = {24'h0, flags_reg[23:16]};
        end else if (hit(avs_address, sysref_cal_pkg::clock_ctrl_addr)) begin
            rd_next = {27'h0, ctrl_reg.step_fine, ctrl_reg.select};
        end else if (hit(avs_address, sysref_cal_pkg::autocal_enable_addr)) begin
            rd_next = {31'h0, enable_reg};
        end else if (hit(avs_address, sysref_cal_pkg::autocal_config_addr)) begin
            rd_next = {24'h0, settle_cfg_reg};
        end else if (hit(avs_address, sysref_cal_pkg::delay_ctrl_addr)) begin
            rd_next = {15'h0, manual_reg.invert, manual_reg.fine, manual_reg.coarse};
        end else if (hit(avs_address, sysref_cal_pkg::autocal_status_addr)) begin
            rd_next = {14'h0, done_reg, result_reg.invert, result_reg.fine, result_reg.coarse};
        end else if (hit(avs_address, sysref_cal_pkg::capture_status_addr)) begin
            rd_next = {29'h0, scan_bit, edge_cnt_reg == sysref_cal_pkg::valid_edge_count,
                found_reg};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_hit) begin
            avs_readdata <= rd_next;
        end
    end

    edge_ends_a: assert property (@(posedge ref_clk) disable iff (reset)
        flags_reg[0] && flags_reg[23]) else $error("end flags not set");
    flags_sample_a: assert property (@(posedge ref_clk) disable iff (reset)
        strobe_rise |=> flags_reg[22:1] == $past(phase_sample[22:1]))
        else $error("flags not sampled");
    idle_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        !enable_reg |=> cal_reg == idle_st) else $error("engine ran while off");
    manual_apply_a: assert property (@(posedge ref_clk) disable iff (reset)
        !enable_reg ##1 !enable_reg |-> delay_applied == $past(manual_reg))
        else $error("manual delay not applied");
    result_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        enable_reg && cal_reg == done_st ##1 enable_reg |-> delay_applied == $past(result_reg))
        else $error("result not applied");
    done_rise_a: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(done_reg) |-> cal_reg == done_st) else $error("done without finish");
    lmfc_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
        strobe_rise |=> lmfc_reg == 5'h00 && lmfc_reset) else $error("lmfc not reset");
    bus_answer_a: assert property (@(posedge ref_clk) disable iff (reset)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest) else $error("slow answer");
    best_small_a: assert property (@(posedge ref_clk) disable iff (reset)
        enable_reg && cal_reg == judge_st && !early_reg && found_reg |=>
        best_reg.coarse <= $past(search_reg.coarse)) else $error("not smallest");
    edge_valid_a: assert property (@(posedge ref_clk) disable iff (reset)
        strobe_rise && edge_cnt_reg == 2'h2 |=> edge_cnt_reg == 2'h3)
        else $error("valid count wrong");
endmodule

/* hdl/sysref_cal_pkg.sv */
// package: register map, field layouts and constants for reference-strobe capture logic
package sysref_cal_pkg;
    // register byte addresses (word index times four where printed offsets are not aligned)
    localparam logic [11:0] flags_low_idx = 12'h02C;
    localparam logic [11:0] flags_mid_idx = 12'h02D;
    localparam logic [11:0] flags_high_idx = 12'h02E;
    localparam logic [13:0] flags_low_addr = {flags_low_idx, 2'b00};
    localparam logic [13:0] flags_mid_addr = {flags_mid_idx, 2'b00};
    localparam logic [13:0] flags_high_addr = {flags_high_idx, 2'b00};
    localparam logic [13:0] clock_ctrl_addr = 14'h0100;
    localparam logic [13:0] autocal_enable_addr = 14'h0104;
    localparam logic [13:0] autocal_config_addr = 14'h0108;
    localparam logic [13:0] delay_ctrl_addr = 14'h010C;
    localparam logic [13:0] autocal_status_addr = 14'h0110;
    localparam logic [13:0] capture_status_addr = 14'h0114;
    // field positions
    localparam int select_lsb = 0;
    localparam int step_fine_bit = 4;
    localparam int coarse_lsb = 0;
    localparam int fine_lsb = 8;
    localparam int invert_bit = 16;
    localparam int result_done_bit = 17;
    // reset values
    localparam logic [3:0] select_reset = 4'h0;
    localparam logic step_fine_reset = 1'b1;
    localparam logic [7:0] settle_reset = 8'h10;
    // widths and counts
    localparam int flag_count = 24;
    localparam int select_count = 16;
    localparam logic [1:0] valid_edge_count = 2'h3;
    localparam int lane_count = 16;
    localparam int lane_rate_mbps = 12800;
    localparam logic [31:0] unmapped_read = 32'h0000_0000;

    typedef struct packed {
        logic invert;
        logic [7:0] coarse;
        logic [7:0] fine;
    } delay_setting_t;

    typedef struct packed {
        logic [3:0] select;
        logic step_fine;
    } capture_ctrl_t;
endpackage

/* hdl/phase_flag_store.sv */
// little memory: per-position capture history, registered read data
`timescale 1ns/1ps
module phase_flag_store #(
    parameter int depth = 24
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic wr_data,
    input wire logic [4:0] rd_addr,
    output logic rd_data
);
    logic [depth-1:0] mem_reg;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mem_reg <= '0;
        end else if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data <= 1'b0;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule

/* verif/strobe_source_model.sv */
// partner model: periodic reference strobe source and clock-edge alignment detector
`timescale 1ns/1ps
module strobe_source_model #(
    parameter int strobe_period = 16
) (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic [7:0] align_noninv,
    input wire logic [7:0] align_inv,
    input wire sysref_cal_pkg::delay_setting_t delay_applied,
    output logic strobe_pin,
    output logic edge_early
);
    int phase_cnt = 0;

    initial strobe_pin = 1'b0;

    // device clock keeps running; strobe is continuous and periodic while run is high
    always @(posedge ref_clk) begin
        phase_cnt <= (phase_cnt == strobe_period - 1) ? 0 : phase_cnt + 1;
        strobe_pin <= (phase_cnt < strobe_period / 2) && ((phase_cnt == 0) ? run : strobe_pin);
    end

    // falling edge still early until coarse delay reaches this polarity's point
    assign edge_early = delay_applied.invert ? (delay_applied.coarse < align_inv)
        : (delay_applied.coarse < align_noninv);
endmodule

/* verif/test_sysref_window_autocal.sv */
// testbench: register access, capture flags, strobe capture and automatic calibration
`timescale 1ns/1ps
module test_sysref_window_autocal;
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
    } note_t;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [13:0] avs_address = 14'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic strobe_pin;
    logic edge_early;
    logic [23:0] phase_sample = 24'h00_0000;
    logic run = 1'b0;
    logic [7:0] align_noninv = 8'h00;
    logic [7:0] align_inv = 8'h00;
    sysref_cal_pkg::delay_setting_t delay_applied;
    sysref_cal_pkg::capture_ctrl_t capture_ctrl;
    logic strobe_captured;
    logic lmfc_reset;
    logic [4:0] lmfc_count;
    logic strobe_prev = 1'b0;
    logic [31:0] rd;
    note_t notes[$];
    int n_errors = 0;
    int checked = 0;
    int pulses = 0;
    int rises = 0;
    int seed = 27538;

    sysref_window_autocal DUT (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .strobe_pin(strobe_pin),
        .phase_sample(phase_sample), .edge_early(edge_early),
        .delay_applied(delay_applied), .capture_ctrl(capture_ctrl),
        .strobe_captured(strobe_captured), .lmfc_reset(lmfc_reset), .lmfc_count(lmfc_count));

    strobe_source_model partner (.ref_clk(ref_clk), .run(run), .align_noninv(align_noninv),
        .align_inv(align_inv), .delay_applied(delay_applied), .strobe_pin(strobe_pin),
        .edge_early(edge_early));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("errors %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic timeout();
        n_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        end_sim();
    endtask

    // one bus transfer; a read leaves its expectation in the queue
    task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d,
        input logic [31:0] exp, input logic [31:0] mask);
        int i;
        note_t n;
        n.exp = exp;
        n.mask = mask;
        @(posedge ref_clk);
        if (!wr) notes.push_back(n);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) timeout();
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic reg_write(input logic [13:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0, 32'h0);
    endtask

    task automatic reg_read(input logic [13:0] a, input logic [31:0] exp, input logic [31:0] mask);
        bus(1'b0, a, 32'h0, exp, mask);
    endtask

    // watcher: completed reads against oldest note, strobe and capture pulse counts
    always @(posedge ref_clk) begin
        note_t n;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            n = notes.pop_front();
            if (n.mask !== 32'h0) check(avs_readdata & n.mask, n.exp, "read data");
        end
        if (!reset && lmfc_reset === 1'b1) begin
            pulses++;
            check({27'h0, lmfc_count}, 32'h0, "multiframe count");
            check({31'h0, strobe_captured}, 32'h1, "strobe captured");
        end
        if (!reset && strobe_pin === 1'b1 && strobe_prev === 1'b0) rises++;
        strobe_prev <= strobe_pin;
    end

    initial begin : main
        logic [23:0] pat;
        logic [23:0] flags;
        logic [3:0] sel;
        logic [7:0] a0;
        logic [7:0] a1;
        logic inv;
        logic [7:0] crs;
        sysref_cal_pkg::delay_setting_t man;
        int k;
        int i;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        reg_read(sysref_cal_pkg::clock_ctrl_addr, 32'h10, 32'h1F);
        reg_read(sysref_cal_pkg::autocal_status_addr, 32'h0, 32'h0002_0000);
        reg_read(sysref_cal_pkg::capture_status_addr, 32'h0, 32'h2);
        reg_read(14'h0200, sysref_cal_pkg::unmapped_read, 32'hFFFF_FFFF);
        // capture flags from a random risk pattern
        pat = 24'($random(seed)) & 24'h7F_FFFE;
        flags = pat | 24'h80_0001;
        phase_sample <= pat;
        run <= 1'b1;
        repeat (128) @(posedge ref_clk);
        reg_read(sysref_cal_pkg::flags_low_addr, {24'h0, flags[7:0]}, 32'hFF);
        reg_read(sysref_cal_pkg::flags_mid_addr, {24'h0, flags[15:8]}, 32'hFF);
        reg_read(sysref_cal_pkg::flags_high_addr, {24'h0, flags[23:16]}, 32'hFF);
        reg_read(sysref_cal_pkg::capture_status_addr, 32'h2, 32'h2);
        // write with byte lane 0 off is dropped
        avs_byteenable <= 4'h0;
        reg_write(sysref_cal_pkg::clock_ctrl_addr, 32'h0F);
        avs_byteenable <= 4'hF;
        reg_read(sysref_cal_pkg::clock_ctrl_addr, 32'h10, 32'h1F);
        for (k = 0; k < 8; k++) begin
            sel = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($random(seed));
            reg_write(sysref_cal_pkg::clock_ctrl_addr, {27'h0, k[0], sel});
            reg_read(sysref_cal_pkg::capture_status_addr, {29'h0, flags[sel], 2'b0}, 32'h4);
            check({27'h0, capture_ctrl}, {27'h0, sel, k[0]}, "capture ctrl");
        end
        run <= 1'b0;
        repeat (20) @(posedge ref_clk);
        check(32'(pulses), 32'(rises), "multiframe resets");
        run <= 1'b1;
        // manual delay rules while calibration is off
        man = '{invert: 1'b1, coarse: 8'($random(seed)), fine: 8'($random(seed))};
        reg_write(sysref_cal_pkg::delay_ctrl_addr, {15'h0, man.invert, man.fine, man.coarse});
        reg_read(sysref_cal_pkg::delay_ctrl_addr, {15'h0, man.invert, man.fine, man.coarse},
            32'h0001_FFFF);
        check({15'h0, delay_applied}, {15'h0, man}, "manual delay");
        reg_write(sysref_cal_pkg::clock_ctrl_addr, 32'h10);
        for (k = 0; k < 2; k++) begin
            a0 = (k == 0) ? 8'h30 + 8'($random(seed) & 32'hF) : 8'h08 + 8'($random(seed) & 32'hF);
            a1 = (k == 0) ? 8'h08 + 8'($random(seed) & 32'hF) : 8'h30 + 8'($random(seed) & 32'hF);
            inv = (k == 0);
            crs = (k == 0) ? a1 : a0;
            align_noninv <= a0;
            align_inv <= a1;
            reg_write(sysref_cal_pkg::autocal_config_addr, 32'h2);
            reg_write(sysref_cal_pkg::autocal_enable_addr, 32'h1);
            for (i = 0; i < 10000; i++) begin
                reg_read(sysref_cal_pkg::autocal_status_addr, 32'h0, 32'h0);
                if (rd[17] === 1'b1) break;
            end
            if (i == 10000) timeout();
            reg_read(sysref_cal_pkg::autocal_status_addr, {14'h0, 1'b1, inv, 8'h0, crs},
                32'h0003_00FF);
            check({23'h0, delay_applied.invert, delay_applied.coarse}, {23'h0, inv, crs},
                "calibrated delay");
            repeat (200) @(posedge ref_clk);
            check({23'h0, delay_applied.invert, delay_applied.coarse}, {23'h0, inv, crs},
                "held delay");
            reg_write(sysref_cal_pkg::autocal_enable_addr, 32'h0);
            reg_read(sysref_cal_pkg::delay_ctrl_addr, {15'h0, man.invert, man.fine, man.coarse},
                32'h0001_FFFF);
            check({15'h0, delay_applied}, {15'h0, man}, "manual after cal");
        end
        end_sim();
    end
endmodule
